// [hw/hrs_pkg.sv]
// shared constants for the switch hot reset sequencer
`default_nettype none
package hrs_pkg;
	// clock and timing
	localparam int CLK_MHZ = 40;
	localparam int TRAIN_LIMIT_MS = 20;
	localparam int CFG_READY_LIMIT_MS = 100;
	// longest times round down
	localparam int TRAIN_LIMIT_CYC = TRAIN_LIMIT_MS * 1000 * CLK_MHZ;
	localparam int CFG_READY_LIMIT_CYC = CFG_READY_LIMIT_MS * 1000 * CLK_MHZ;
	// sequencer leaves training for load or run once its training cycle count reaches this value
	localparam int TRAIN_START_CYC = 16;
	localparam int CNT_W = 32;
	localparam int NUM_DS = 5;
	localparam int ERR_W = 4;
	// completion status codes
	localparam logic [1:0] CPL_SC = 2'h0;
	localparam logic [1:0] CPL_CRS = 2'h2;
	// reset values
	localparam logic HALT_RST = 1'b0;
	localparam logic DONE_RST = 1'b0;
	localparam logic [ERR_W-1:0] ERR_RST = 4'h0;
	// sequencer states
	typedef enum logic [5:0] {
		ST_RUN = 6'h01,
		ST_HOT = 6'h02,
		ST_TRAIN = 6'h04,
		ST_LOAD = 6'h08,
		ST_HALT = 6'h10,
		ST_FUND = 6'h20
	} hrs_state_t;
endpackage
`default_nettype wire

// [hw/hrs_sequencer.sv]
// switch hot reset sequencer: triggers, quasi-reset window, eeprom reload, halt
`default_nettype none

// ----------------------------------------
// sequencer
// ----------------------------------------
// What this block does
// - answer config requests with retry status while eeprom init runs
// - eeprom writes with side effects start them at that write
// - fundamental reset write completes successfully before warm reset starts
// - fundamental reset turns all gpio pins to inputs, port resets undriven
// - hot reset on upstream ts1 hot reset, dl_down, or software bit
// - linkdown disable blocks only the dl_down trigger
// - downstream ports with link up send ts1 hot reset during hot reset
// - hot reset resets all logic except plls, serdes, both smbus
// - hot reset restores registers except sticky and writable when unlocked
// - links enter training within 20 ms of reset clearing
// - within 100 ms config gets retry status, others ignored in quasi-reset
// - eeprom reload only if mode needs it and disable bit clear
// - eeprom full link retrain write retrains that port with current parameters
// - eeprom error aborts load, sets halt bit, records error details
// - done flag set on eeprom finish or error
// - halt bit holds logic in reset except smbus; only loader sets it
// - slave smbus works in hot reset; affected reads zero, writes dropped
// - hot reset bit write completes before hot reset sequence begins
// - software hot reset fully retrains upstream link to detect
// - stay halted until smbus clears halt bit, then continue
module hrs_sequencer (
	input wire logic sys_clk, // 40 mhz clock
	input wire logic rst_n, // async reset, active low
	input wire logic us_ts1_hot_reset, // pin: ts1 hot reset seen upstream
	input wire logic us_dl_down, // pin: upstream dl layer is down
	input wire logic hot_reset_bit, // same clock: sw wrote hot reset
	input wire logic fundamental_reset_bit, // same clock: sw wrote fundamental reset
	input wire logic linkdown_hot_reset_disable, // config: ignore dl_down trigger
	input wire logic hot_reset_eeprom_init_disable, // config: skip eeprom reload
	input wire logic mode_needs_eeprom, // switch mode needs eeprom init
	input wire logic [hrs_pkg::NUM_DS-1:0] ds_link_up, // pins: downstream link up
	input wire logic cfg_req, // config request pulse
	input wire logic cfg_wr, // request is a write
	input wire logic other_req, // non-config transaction pulse
	input wire logic ee_wr, // eeprom loader register write pulse
	input wire logic ee_wr_side_effect, // written field has a side effect
	input wire logic ee_wr_full_link_retrain_bit, // write sets full link retrain bit
	input wire logic [hrs_pkg::NUM_DS:0] ee_wr_port, // one-hot target port
	input wire logic ee_done, // loader finished
	input wire logic ee_err, // loader error pulse
	input wire logic [hrs_pkg::ERR_W-1:0] ee_err_code, // error details
	input wire logic smb_halt_clear, // slave smbus clears halt bit
	input wire logic smb_rd, // slave smbus read of reset-affected reg
	input wire logic smb_wr, // slave smbus write of reset-affected reg
	output logic cpl_valid, // completion pulse
	output logic [1:0] cpl_status, // completion status
	output logic req_drop, // non-config transaction dropped
	output logic [hrs_pkg::NUM_DS-1:0] ds_ts1_hot, // send ts1 hot reset
	output logic [hrs_pkg::NUM_DS-1:0] gpio_oe, // gpio output enables
	output logic logic_rst, // core logic reset
	output logic reg_rst, // non-sticky register reset
	output logic links_train, // links in active training
	output logic us_to_detect, // upstream ltssm to detect pulse
	output logic [hrs_pkg::NUM_DS:0] retrain, // per port retrain pulse
	output logic side_effect, // side effect start pulse
	output logic ee_start, // eeprom load start pulse
	output logic ee_abort, // eeprom abort pulse
	output logic reset_halt_bit, // halt bit of switch_control_reg
	output logic ee_done_flag, // done flag of smbus_status_reg
	output logic [hrs_pkg::ERR_W-1:0] ee_err_info, // error of smbus_status_reg
	output logic quasi_reset, // stacks in quasi-reset
	output logic smb_rd_zero, // smbus read returns zero
	output logic smb_wr_drop, // smbus write discarded
	output logic warm_reset // warm reset request
);
	hrs_pkg::hrs_state_t state;
	logic [1:0] ts1_sync;
	logic [1:0] dld_sync;
	logic [hrs_pkg::NUM_DS-1:0] lu_s1;
	logic [hrs_pkg::NUM_DS-1:0] lu_s2;
	logic dld_prev;
	logic pend_hot;
	logic pend_sw;
	logic pend_fund;
	logic [hrs_pkg::CNT_W-1:0] cnt;
	logic trigger;
	logic dld_edge;
	logic in_reset;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	// two flops each; only the second stage is read
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ts1_sync <= 2'h0;
			dld_sync <= 2'h0;
			lu_s1 <= '0;
			lu_s2 <= '0;
			dld_prev <= 1'b0;
		end else begin
			ts1_sync <= {ts1_sync[0], us_ts1_hot_reset};
			dld_sync <= {dld_sync[0], us_dl_down};
			lu_s1 <= ds_link_up;
			lu_s2 <= lu_s1;
			dld_prev <= dld_sync[1];
		end
	end

	// trigger sources; only the entry into dl_down counts
	assign dld_edge = dld_sync[1] && !dld_prev && !linkdown_hot_reset_disable;
	assign trigger = ts1_sync[1] || dld_edge;
	assign in_reset = (state == hrs_pkg::ST_HOT) || (state == hrs_pkg::ST_HALT);

	// ----------------------------------------
	// completions
	// ----------------------------------------
	// software writes are completed first, the reset begins next cycle
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cpl_valid <= 1'b0;
			cpl_status <= hrs_pkg::CPL_SC;
			req_drop <= 1'b0;
			pend_sw <= 1'b0;
			pend_fund <= 1'b0;
		end else begin
			cpl_valid <= cfg_req;
			req_drop <= other_req && quasi_reset;
			pend_sw <= cfg_req && cfg_wr && hot_reset_bit && !quasi_reset;
			pend_fund <= cfg_req && cfg_wr && fundamental_reset_bit && !quasi_reset;
			if (quasi_reset || state == hrs_pkg::ST_LOAD)
				cpl_status <= hrs_pkg::CPL_CRS;
			else
				cpl_status <= hrs_pkg::CPL_SC;
		end
	end

	// ----------------------------------------
	// state machine
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= hrs_pkg::ST_RUN;
			cnt <= '0;
			pend_hot <= 1'b0;
			us_to_detect <= 1'b0;
			ee_start <= 1'b0;
		end else begin
			us_to_detect <= 1'b0;
			ee_start <= 1'b0;
			case (state)
				hrs_pkg::ST_RUN: begin
					if (pend_fund) begin
						state <= hrs_pkg::ST_FUND;
					end else if (trigger || pend_sw) begin
						state <= hrs_pkg::ST_HOT;
						us_to_detect <= pend_sw;
					end
				end
				hrs_pkg::ST_HOT: begin
					cnt <= '0;
					// held while the triggering condition stands
					if (!ts1_sync[1] && !(dld_sync[1] && !linkdown_hot_reset_disable))
						state <= hrs_pkg::ST_TRAIN;
				end
				hrs_pkg::ST_TRAIN: begin
					cnt <= cnt + 1'b1;
					if (trigger) begin
						state <= hrs_pkg::ST_HOT;
					end else if (cnt >= hrs_pkg::CNT_W'(hrs_pkg::TRAIN_START_CYC)) begin
						if (mode_needs_eeprom && !hot_reset_eeprom_init_disable) begin
							state <= hrs_pkg::ST_LOAD;
							ee_start <= 1'b1;
						end else begin
							state <= hrs_pkg::ST_RUN;
						end
					end
				end
				hrs_pkg::ST_LOAD: begin
					if (ee_err)
						state <= hrs_pkg::ST_HALT;
					else if (ee_done)
						state <= hrs_pkg::ST_RUN;
				end
				hrs_pkg::ST_HALT: begin
					if (!reset_halt_bit)
						state <= hrs_pkg::ST_RUN;
				end
				hrs_pkg::ST_FUND: state <= hrs_pkg::ST_FUND;
				default: state <= hrs_pkg::ST_RUN;
			endcase
		end
	end

	// ----------------------------------------
	// reset outputs
	// ----------------------------------------
	// training starts a fixed short time after clear, far below the limits
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			logic_rst <= 1'b0;
			reg_rst <= 1'b0;
			links_train <= 1'b0;
			quasi_reset <= 1'b0;
			ds_ts1_hot <= '0;
			gpio_oe <= '0;
			warm_reset <= 1'b0;
		end else begin
			logic_rst <= in_reset || reset_halt_bit;
			reg_rst <= (state == hrs_pkg::ST_HOT);
			links_train <= (state == hrs_pkg::ST_TRAIN) || (state == hrs_pkg::ST_LOAD);
			quasi_reset <= (state != hrs_pkg::ST_RUN);
			ds_ts1_hot <= (state == hrs_pkg::ST_HOT) ? lu_s2 : '0;
			warm_reset <= (state == hrs_pkg::ST_FUND);
			// gpio default to inputs: port resets stay tri-stated
			gpio_oe <= '0;
		end
	end

	// ----------------------------------------
	// eeprom loader effects
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			retrain <= '0;
			side_effect <= 1'b0;
			ee_abort <= 1'b0;
		end else begin
			side_effect <= ee_wr && ee_wr_side_effect && (state == hrs_pkg::ST_LOAD);
			retrain <= (ee_wr && ee_wr_full_link_retrain_bit && state == hrs_pkg::ST_LOAD) ? ee_wr_port : '0;
			ee_abort <= ee_err && (state == hrs_pkg::ST_LOAD);
		end
	end

	// ----------------------------------------
	// status bits
	// ----------------------------------------
	// smbus domain, not hit by hot reset; halt set wins over smbus clear, done clear at ee_start wins over set
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reset_halt_bit <= hrs_pkg::HALT_RST;
			ee_done_flag <= hrs_pkg::DONE_RST;
			ee_err_info <= hrs_pkg::ERR_RST;
		end else begin
			if (ee_start)
				ee_done_flag <= 1'b0;
			else if (state == hrs_pkg::ST_LOAD && (ee_done || ee_err))
				ee_done_flag <= 1'b1;
			if (state == hrs_pkg::ST_LOAD && ee_err) begin
				reset_halt_bit <= 1'b1;
				ee_err_info <= ee_err_code;
			end else if (smb_halt_clear) begin
				reset_halt_bit <= 1'b0;
			end
		end
	end

	// slave smbus answers for reset-affected registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			smb_rd_zero <= 1'b0;
			smb_wr_drop <= 1'b0;
		end else begin
			smb_rd_zero <= smb_rd && in_reset;
			smb_wr_drop <= smb_wr && in_reset;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	crs_during_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cfg_req && state == hrs_pkg::ST_LOAD |=> cpl_status == hrs_pkg::CPL_CRS)
		else $error("config answered without retry during load");
	fund_cpl_first_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		warm_reset && !$past(warm_reset) |-> $past(cpl_valid, 2))
		else $error("warm reset before completion");
	gpio_input_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		gpio_oe == '0)
		else $error("gpio driven");
	dld_disable_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state == hrs_pkg::ST_RUN && linkdown_hot_reset_disable && !ts1_sync[1] && !pend_sw
		&& !pend_fund |=> state == hrs_pkg::ST_RUN)
		else $error("hot reset on disabled link down");
	ts1_prop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state == hrs_pkg::ST_HOT |=> ds_ts1_hot == $past(lu_s2))
		else $error("ts1 hot reset not propagated");
	train_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state == hrs_pkg::ST_HOT ##1 state == hrs_pkg::ST_TRAIN |-> ##[1:20] links_train
		|| state == hrs_pkg::ST_HOT || state == hrs_pkg::ST_RUN)
		else $error("training late");
	reload_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ee_start |-> mode_needs_eeprom && !hot_reset_eeprom_init_disable)
		else $error("eeprom reload not allowed");
	err_halt_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state == hrs_pkg::ST_LOAD && ee_err |=> reset_halt_bit && ee_done_flag
		##1 logic_rst)
		else $error("error did not halt");
	halt_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		reset_halt_bit |=> logic_rst)
		else $error("logic running while halted");
	sw_detect_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		us_to_detect |-> state == hrs_pkg::ST_HOT && $past(pend_sw))
		else $error("detect without software reset");
	halt_exit_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state == hrs_pkg::ST_HALT && !reset_halt_bit |=> state == hrs_pkg::ST_RUN)
		else $error("halt not left");
	load_done_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
		state == hrs_pkg::ST_LOAD ##1 state == hrs_pkg::ST_RUN);
	halt_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
		state == hrs_pkg::ST_HALT ##[1:50] state == hrs_pkg::ST_RUN);
	sw_hot_c: cover property (@(posedge sys_clk) disable iff (!rst_n) us_to_detect);
endmodule
`default_nettype wire

// [tb/hrs_host_model.sv]
// upstream host model issuing configuration requests to the sequencer
`default_nettype none
module hrs_host_model (
	input wire logic sys_clk, // bench clock
	output logic cfg_req, // config request pulse
	output logic cfg_wr, // request is a write
	output logic hot_reset_bit, // write data: hot reset
	output logic fundamental_reset_bit, // write data: fundamental reset
	output logic other_req, // non-config request pulse
	input wire logic cpl_valid, // completion pulse
	input wire logic [1:0] cpl_status // completion status
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cfg_req = 1'b0;
		cfg_wr = 1'b0;
		hot_reset_bit = 1'b0;
		fundamental_reset_bit = 1'b0;
		other_req = 1'b0;
	end
	// one request, then a bounded wait; no answer leaves the status unknown
	task automatic cfg(input logic wr, input logic hr, input logic fr, output logic [1:0] st);
		int i;
		st = 2'bxx;
		@(negedge sys_clk);
		cfg_req = 1'b1;
		cfg_wr = wr;
		hot_reset_bit = hr;
		fundamental_reset_bit = fr;
		@(negedge sys_clk);
		cfg_req = 1'b0;
		// write data drops with the strobe, in the same time step
		hot_reset_bit = 1'b0;
		fundamental_reset_bit = 1'b0;
		for (i = 0; i < 4 && cpl_valid !== 1'b1; i++) @(negedge sys_clk);
		if (cpl_valid === 1'b1) st = cpl_status;
	endtask
	// one non-config transaction
	task automatic other();
		@(negedge sys_clk);
		other_req = 1'b1;
		@(negedge sys_clk);
		other_req = 1'b0;
	endtask
endmodule
`default_nettype wire

// [tb/switch_hot_reset_sequencer_tb_top.sv]
// self-checking bench for the hot reset sequencer
`default_nettype none
module switch_hot_reset_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk, rst_n, ts1, dl_down, cfg_req, cfg_wr, hrb, frb, other_req, ld_dis, ee_dis, mode;
	logic ee_wr, ee_se, ee_fl, ee_done, ee_err, smb_clr, smb_rd, smb_wr, cpl_valid, req_drop;
	logic logic_rst, reg_rst, links_train, us_to_detect, side_effect, ee_start, ee_abort, halt;
	logic done_flag, quasi, smb_rd_zero, smb_wr_drop, warm_reset;
	logic [4:0] ds_up, ds_ts1, gpio_oe;
	logic [5:0] ee_port, retrain, rt_seen;
	logic [3:0] ecode, err_info;
	logic [1:0] cpl_status, st;
	int miscompares, checked, n_det, n_drop, n_se, n_st, n_rz, n_wd, n_ab, mdl_quasi;
	hrs_sequencer hrs_sequencer_inst (.sys_clk(sys_clk), .rst_n(rst_n), .us_ts1_hot_reset(ts1),
		.us_dl_down(dl_down), .hot_reset_bit(hrb), .fundamental_reset_bit(frb),
		.linkdown_hot_reset_disable(ld_dis), .hot_reset_eeprom_init_disable(ee_dis),
		.mode_needs_eeprom(mode), .ds_link_up(ds_up), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
		.other_req(other_req), .ee_wr(ee_wr), .ee_wr_side_effect(ee_se), .ee_wr_full_link_retrain_bit(ee_fl),
		.ee_wr_port(ee_port), .ee_done(ee_done), .ee_err(ee_err), .ee_err_code(ecode),
		.smb_halt_clear(smb_clr), .smb_rd(smb_rd), .smb_wr(smb_wr), .cpl_valid(cpl_valid),
		.cpl_status(cpl_status), .req_drop(req_drop), .ds_ts1_hot(ds_ts1), .gpio_oe(gpio_oe),
		.logic_rst(logic_rst), .reg_rst(reg_rst), .links_train(links_train),
		.us_to_detect(us_to_detect), .retrain(retrain), .side_effect(side_effect),
		.ee_start(ee_start), .ee_abort(ee_abort), .reset_halt_bit(halt),
		.ee_done_flag(done_flag), .ee_err_info(err_info), .quasi_reset(quasi),
		.smb_rd_zero(smb_rd_zero), .smb_wr_drop(smb_wr_drop), .warm_reset(warm_reset));
	hrs_host_model hrs_host_model_inst (.sys_clk(sys_clk), .cfg_req(cfg_req), .cfg_wr(cfg_wr),
		.hot_reset_bit(hrb), .fundamental_reset_bit(frb), .other_req(other_req),
		.cpl_valid(cpl_valid), .cpl_status(cpl_status));
	// ----------------------------------------
	// clock, pulse counters, watchdog
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	// pulses are counted so a check may look a few cycles later
	always @(posedge sys_clk) begin
		n_det += (us_to_detect === 1'b1);
		n_drop += (req_drop === 1'b1);
		n_se += (side_effect === 1'b1);
		n_st += (ee_start === 1'b1);
		n_rz += (smb_rd_zero === 1'b1);
		n_wd += (smb_wr_drop === 1'b1);
		n_ab += (ee_abort === 1'b1);
		if (retrain !== 6'h00) rt_seen = retrain;
	end
	// the tests need under 400 cycles; a hang is cut well after that
	initial begin
		#(4000 * 25);
		miscompares++;
		summarize();
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
		checked++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// bounded wait for the quasi-reset level, then compare with the model
	task automatic wq(input logic v);
		int i;
		for (i = 0; i < 60 && quasi !== v; i++) @(negedge sys_clk);
		mdl_quasi = v;
		chk(quasi, v, "quasi reset level");
	endtask
	task automatic req(input logic wr, input logic hr, input logic fr);
		hrs_host_model_inst.cfg(wr, hr, fr, st);
		chk(st, mdl_quasi ? hrs_pkg::CPL_CRS : hrs_pkg::CPL_SC, "completion status");
	endtask
	task automatic pulse_ee(input logic w, input logic e, input logic d, input logic c);
		@(negedge sys_clk);
		{ee_wr, ee_err, ee_done, smb_clr} = {w, e, d, c};
		@(negedge sys_clk);
		{ee_wr, ee_err, ee_done, smb_clr} = 4'h0;
	endtask
	task automatic summarize();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		{rst_n, ts1, dl_down, ld_dis, ee_dis, ee_wr, ee_se, ee_fl, ee_done, ee_err} = 10'h000;
		{smb_clr, smb_rd, smb_wr} = 3'h0;
		mode = 1'b1;
		ds_up = 5'h15;
		ee_port = 6'h00;
		ecode = 4'h0;
		rt_seen = 6'h00;
		mdl_quasi = 0;
		cyc(5);
		rst_n = 1'b1;
		void'($urandom(91));
		cyc(3);
		req(1'b0, 1'b0, 1'b0);
		hrs_host_model_inst.other();
		cyc(2);
		chk(n_drop, 0, "drop outside reset");
		$display("test normal done");
		req(1'b1, 1'b1, 1'b0);
		// reset outputs stand for the single hot cycle only
		cyc(2);
		chk(n_det, 1, "upstream to detect");
		chk({logic_rst, reg_rst}, 2'h3, "logic and register reset");
		chk(ds_ts1, ds_up, "ts1 on live ports");
		wq(1'b1);
		req(1'b0, 1'b0, 1'b0);
		hrs_host_model_inst.other();
		cyc(2);
		chk(n_drop, 1, "other dropped");
		chk(links_train, 1'b1, "links training");
		for (int i = 0; i < 40 && n_st == 0; i++) cyc(1);
		chk(n_st, 1, "eeprom start");
		req(1'b0, 1'b0, 1'b0);
		{ee_se, ee_fl, ee_port} = {2'h3, 6'h04};
		pulse_ee(1'b1, 1'b0, 1'b0, 1'b0);
		cyc(2);
		chk(rt_seen, 6'h04, "retrain port");
		chk(n_se, 1, "side effect at write");
		ecode = 4'(1 + $urandom % 15);
		pulse_ee(1'b0, 1'b1, 1'b0, 1'b0);
		cyc(1);
		chk({halt, done_flag, err_info}, {2'h3, ecode}, "halt, done, error");
		chk(logic_rst, 1'b1, "held in halt");
		chk(n_ab, 1, "eeprom abort");
		@(negedge sys_clk) smb_rd = 1'b1;
		@(negedge sys_clk) {smb_rd, smb_wr} = 2'h1;
		@(negedge sys_clk) smb_wr = 1'b0;
		cyc(2);
		chk({n_rz[3:0], n_wd[3:0]}, 8'h11, "smbus zero and drop");
		pulse_ee(1'b0, 1'b0, 1'b0, 1'b1);
		cyc(3);
		chk(halt, 1'b0, "halt cleared");
		wq(1'b0);
		req(1'b0, 1'b0, 1'b0);
		$display("test software hot reset done");
		ld_dis = 1'b1;
		dl_down = 1'b1;
		cyc(8);
		chk(quasi, 1'b0, "link down disabled");
		{dl_down, ld_dis, ee_dis} = 3'h1;
		cyc(3);
		dl_down = 1'b1;
		wq(1'b1);
		dl_down = 1'b0;
		wq(1'b0);
		chk(n_st, 1, "no reload when disabled");
		ts1 = 1'b1;
		wq(1'b1);
		ts1 = 1'b0;
		wq(1'b0);
		$display("test pin triggers done");
		req(1'b1, 1'b0, 1'b1);
		cyc(3);
		chk({warm_reset, gpio_oe}, 6'h20, "warm reset, pins inputs");
		$display("test fundamental reset done");
		// only a reset pin pulse leaves the fundamental state
		rst_n = 1'b0;
		cyc(2);
		chk({warm_reset, quasi, halt, done_flag, cpl_valid}, 5'h00, "outputs in reset");
		rst_n = 1'b1;
		cyc(2);
		req(1'b0, 1'b0, 1'b0);
		$display("test reset release done");
		summarize();
	end
endmodule
`default_nettype wire
